// file: verilog/amo_pkg.sv
// Constants and carrier types for the alarm mask and offset trim bank.
// Assumes a 32-bit AXI4-Lite slave with 12-bit byte addresses.
package amo_pkg;

////////////////////////////////////////////////////////////////////////////
	localparam int unsigned AMO_ADDR_W = 12;
	localparam int unsigned AMO_IDX_W  = 10;
	localparam int unsigned AMO_TRIM_W = 12;
	localparam int unsigned AMO_LANES  = 8;

	// Register indices; byte address is four times the index
	localparam logic [9:0] AMO_IDX_STATUS  = 10'h2c1;
	localparam logic [9:0] AMO_IDX_MASK    = 10'h2c2;
	localparam logic [9:0] AMO_IDX_LANE    = 10'h2c4;
	localparam logic [9:0] AMO_IDX_SUMMARY = 10'h2c6;
	localparam logic [9:0] AMO_IDX_CALSTAT = 10'h2c8;
	localparam logic [9:0] AMO_IDX_TRIM0   = 10'h330;
	localparam logic [9:0] AMO_IDX_TRIM1   = 10'h332;

	localparam logic [7:0]  AMO_STATUS_RST = 8'h3f;
	localparam logic [7:0]  AMO_MASK_RST   = 8'h3f;
	localparam logic [7:0]  AMO_LANE_RST   = 8'hff;
	localparam logic [15:0] AMO_TRIM_RST   = 16'h0000;

	// Alarm field positions, shared by status and mask
	localparam int unsigned AMO_BIT_FIFO    = 5;
	localparam int unsigned AMO_BIT_PLL     = 4;
	localparam int unsigned AMO_BIT_LINK    = 3;
	localparam int unsigned AMO_BIT_REALIGN = 2;
	localparam int unsigned AMO_BIT_CLK     = 0;
	// Real sources only; reserved positions never reach the summary
	localparam logic [7:0]  AMO_SRC_BITS    = 8'h3d;

	// Calibration status register fields
	localparam int unsigned AMO_BIT_ACCESS_OK = 0;
	localparam int unsigned AMO_BIT_SPARE_FG  = 1;
	localparam int unsigned AMO_BIT_CAL_RUN   = 2;

	localparam logic [1:0] AMO_RESP_OKAY   = 2'h0;
	localparam logic [1:0] AMO_RESP_SLVERR = 2'h2;

////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] lane_fifo_error;
		logic       serializer_pll_unlock;
		logic       link_state_bad;
		logic       clock_realign;
		logic       divider_mismatch;
	} amo_alarm_src_type;

	typedef struct packed {
		logic offset_cal_enable;
		logic background_cal_enable;
		logic continuous_offset_tracking_enable;
		logic foreground_cal_complete;
		logic offset_cal_running;
	} amo_cal_state_type;

endpackage : amo_pkg

// file: verilog/amo_lane_flags.sv
// Sticky per-lane FIFO overflow/underflow flags, write-one-to-clear.
// Assumes error and clear inputs come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module amo_lane_flags
	import amo_pkg::*;
#(
	parameter int unsigned LANES = amo_pkg::AMO_LANES
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [LANES-1:0] lane_error,
	input  wire logic [LANES-1:0] clear_bits,
	input  wire logic             clear_all,
	output logic      [LANES-1:0] flags
);

////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [LANES-1:0] flags;
	} amo_lane_state_type;

	amo_lane_state_type s;
	amo_lane_state_type next_s;

	always_comb begin
		next_s = s;
		if (clear_all) begin
			next_s.flags = '0;
		end else begin
			next_s.flags = s.flags & ~clear_bits;
		end
		// Set beats clear, so a persisting fault trips again at once
		next_s.flags = next_s.flags | lane_error;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s.flags <= LANES'(AMO_LANE_RST);
		end else begin
			s <= next_s;
		end
	end

	assign flags = s.flags;

endmodule : amo_lane_flags
`default_nettype wire

// file: verilog/amo_trim_apply.sv
// Adds an unsigned offset trim to one converter core's sample stream.
// Assumes SAMPLE_W is at least the trim width; result saturates.
`timescale 1ns/10ps
`default_nettype none
module amo_trim_apply
	import amo_pkg::*;
#(
	parameter int unsigned SAMPLE_W = 12
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [SAMPLE_W-1:0]   sample,
	input  wire logic                  sample_valid,
	input  wire logic [AMO_TRIM_W-1:0] trim,
	output logic      [SAMPLE_W-1:0]   corrected,
	output logic                       corrected_valid
);

////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [SAMPLE_W-1:0] data;
		logic                valid;
	} amo_trim_state_type;

	amo_trim_state_type s;
	amo_trim_state_type next_s;
	logic [SAMPLE_W:0]  sum;

	always_comb begin
		next_s = s;
		sum = {1'b0, sample} + (SAMPLE_W+1)'(trim);
		next_s.valid = sample_valid;
		if (sample_valid) begin
			// Clip instead of wrapping: a wrap would look like a full-scale jump
			next_s.data = sum[SAMPLE_W] ? '1 : sum[SAMPLE_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign corrected = s.data;
	assign corrected_valid = s.valid;

endmodule : amo_trim_apply
`default_nettype wire

// file: verilog/amo_regs.sv
// Alarm mask, alarm status, lane FIFO alarms and core 0/1 offset trims.
// Assumes alarm sources and calibration state come from same-clock logic.
`timescale 1ns/10ps
`default_nettype none
module amo_regs
	import amo_pkg::*;
#(
	parameter int unsigned SAMPLE_W = 12
) (
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	input  wire logic [amo_pkg::AMO_ADDR_W-1:0]  awaddr,
	input  wire logic                            awvalid,
	output logic                                 awready,
	input  wire logic [31:0]                     wdata,
	input  wire logic [3:0]                      wstrb,
	input  wire logic                            wvalid,
	output logic                                 wready,
	output logic [1:0]                           bresp,
	output logic                                 bvalid,
	input  wire logic                            bready,
	input  wire logic [amo_pkg::AMO_ADDR_W-1:0]  araddr,
	input  wire logic                            arvalid,
	output logic                                 arready,
	output logic [31:0]                          rdata,
	output logic [1:0]                           rresp,
	output logic                                 rvalid,
	input  wire logic                            rready,
	input  wire amo_pkg::amo_alarm_src_type      alarm_src,
	input  wire logic                            soft_reset,
	input  wire amo_pkg::amo_cal_state_type      cal_state,
	output logic                                 summary_alarm,
	output logic                                 spare_core_fg_offset_cal,
	input  wire logic [SAMPLE_W-1:0]             core0_sample,
	input  wire logic                            core0_sample_valid,
	output logic [SAMPLE_W-1:0]                  core0_corrected,
	output logic                                 core0_corrected_valid,
	input  wire logic [SAMPLE_W-1:0]             core1_sample,
	input  wire logic                            core1_sample_valid,
	output logic [SAMPLE_W-1:0]                  core1_corrected,
	output logic                                 core1_corrected_valid
);

////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic                  aw_held;
		logic [AMO_ADDR_W-1:0] aw_addr;
		logic                  w_held;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic [7:0]            status;
		logic [7:0]            mask;
		logic [15:0]           trim0;
		logic [15:0]           trim1;
		logic                  summary;
		logic [2:0]            calstat;
	} amo_regs_state_type;

	amo_regs_state_type s;
	amo_regs_state_type next_s;

	function automatic logic [AMO_IDX_W-1:0] amo_index(
		input logic [AMO_ADDR_W-1:0] addr
	);
		return addr[AMO_ADDR_W-1:2];
	endfunction : amo_index

	function automatic logic amo_mapped(input logic [AMO_IDX_W-1:0] idx);
		return (idx == AMO_IDX_STATUS) || (idx == AMO_IDX_MASK) ||
			(idx == AMO_IDX_LANE) || (idx == AMO_IDX_SUMMARY) ||
			(idx == AMO_IDX_CALSTAT) || (idx == AMO_IDX_TRIM0) ||
			(idx == AMO_IDX_TRIM1);
	endfunction : amo_mapped

	// Byte-lane merge for registers of up to 16 bits
	function automatic logic [15:0] amo_merge(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction : amo_merge

////////////////////////////////////////////////////////////////////////////
	logic [7:0]            lane_flags;
	logic [7:0]            lane_clear;
	logic                  lane_clear_all;
	logic                  have_aw;
	logic                  have_w;
	logic [AMO_ADDR_W-1:0] wr_addr;
	logic [31:0]           wr_data;
	logic [3:0]            wr_strb;
	logic [AMO_IDX_W-1:0]  wr_idx;
	logic [AMO_IDX_W-1:0]  rd_idx;
	logic                  do_write;
	logic [7:0]            status_clr;
	logic [7:0]            status_set;
	logic                  tracking_full;
	logic                  access_ok;

	assign awready = !s.aw_held && !s.bvalid;
	assign wready  = !s.w_held && !s.bvalid;
	assign arready = !s.rvalid;

	always_comb begin
		next_s = s;
		lane_clear = '0;
		lane_clear_all = 1'b0;
		status_clr = '0;

		// Write channel: address and data may arrive in either order
		have_aw = s.aw_held || (awvalid && awready);
		have_w  = s.w_held || (wvalid && wready);
		wr_addr = s.aw_held ? s.aw_addr : awaddr;
		wr_data = s.w_held ? s.w_data : wdata;
		wr_strb = s.w_held ? s.w_strb : wstrb;
		wr_idx  = amo_index(wr_addr);
		do_write = have_aw && have_w;
		if (do_write) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = amo_mapped(wr_idx) ? AMO_RESP_OKAY
				: AMO_RESP_SLVERR;
			if (wr_strb[0]) begin
				case (wr_idx)
					AMO_IDX_STATUS: begin
						status_clr = wr_data[7:0];
						lane_clear_all = wr_data[AMO_BIT_FIFO];
					end
					AMO_IDX_LANE: begin
						lane_clear = wr_data[7:0];
					end
					default: begin
					end
				endcase
			end
			case (wr_idx)
				AMO_IDX_MASK: begin
					next_s.mask = 8'(amo_merge({8'h00, s.mask}, wr_data,
						wr_strb & 4'h1));
				end
				AMO_IDX_TRIM0: begin
					next_s.trim0 = amo_merge(s.trim0, wr_data, wr_strb);
				end
				AMO_IDX_TRIM1: begin
					next_s.trim1 = amo_merge(s.trim1, wr_data, wr_strb);
				end
				default: begin
				end
			endcase
		end else begin
			if (awvalid && awready) begin
				next_s.aw_held = 1'b1;
				next_s.aw_addr = awaddr;
			end
			if (wvalid && wready) begin
				next_s.w_held = 1'b1;
				next_s.w_data = wdata;
				next_s.w_strb = wstrb;
			end
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end

		// Alarm status: hardware set wins over a same-cycle clear
		status_set = '0;
		status_set[AMO_BIT_FIFO] = |alarm_src.lane_fifo_error;
		status_set[AMO_BIT_PLL] = alarm_src.serializer_pll_unlock;
		status_set[AMO_BIT_LINK] = alarm_src.link_state_bad;
		status_set[AMO_BIT_REALIGN] = alarm_src.clock_realign;
		status_set[AMO_BIT_CLK] = alarm_src.divider_mismatch;
		next_s.status = ((s.status & ~status_clr) | status_set)
			& AMO_STATUS_RST;
		if (soft_reset) begin
			next_s.status = AMO_STATUS_RST;
		end

		// Reserved status bit 1 is excluded even when its mask bit is zero
		next_s.summary = |(next_s.status & ~next_s.mask
			& AMO_SRC_BITS);

		// Advisory only: software must still obey the access window
		tracking_full = cal_state.background_cal_enable &&
			cal_state.continuous_offset_tracking_enable;
		if (cal_state.offset_cal_running) begin
			access_ok = 1'b0;
		end else if (tracking_full) begin
			access_ok = 1'b0;
		end else if (cal_state.offset_cal_enable) begin
			access_ok = cal_state.foreground_cal_complete;
		end else begin
			access_ok = 1'b1;
		end
		next_s.calstat = '0;
		next_s.calstat[AMO_BIT_ACCESS_OK] = access_ok;
		next_s.calstat[AMO_BIT_SPARE_FG] = cal_state.offset_cal_enable &&
			cal_state.background_cal_enable &&
			!cal_state.continuous_offset_tracking_enable;
		next_s.calstat[AMO_BIT_CAL_RUN] = cal_state.offset_cal_running;

		// Read channel: no side effects on any register
		rd_idx = amo_index(araddr);
		if (arvalid && arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = amo_mapped(rd_idx) ? AMO_RESP_OKAY
				: AMO_RESP_SLVERR;
			case (rd_idx)
				AMO_IDX_STATUS:  next_s.rdata = {24'h000000, s.status};
				AMO_IDX_MASK:    next_s.rdata = {24'h000000, s.mask};
				AMO_IDX_LANE:    next_s.rdata = {24'h000000, lane_flags};
				AMO_IDX_SUMMARY: next_s.rdata = {31'h00000000, s.summary};
				AMO_IDX_CALSTAT: next_s.rdata = {29'h00000000, s.calstat};
				AMO_IDX_TRIM0:   next_s.rdata = {16'h0000, s.trim0};
				AMO_IDX_TRIM1:   next_s.rdata = {16'h0000, s.trim1};
				default:         next_s.rdata = 32'h00000000;
			endcase
		end else if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.status <= AMO_STATUS_RST;
			s.mask <= AMO_MASK_RST;
			s.trim0 <= AMO_TRIM_RST;
			s.trim1 <= AMO_TRIM_RST;
			s.summary <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

////////////////////////////////////////////////////////////////////////////
	amo_lane_flags #(
		.LANES(AMO_LANES)
	) u_lane_flags (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.lane_error (alarm_src.lane_fifo_error),
		.clear_bits (lane_clear),
		.clear_all  (lane_clear_all),
		.flags      (lane_flags)
	);

	amo_trim_apply #(
		.SAMPLE_W(SAMPLE_W)
	) u_core0_trim (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.sample          (core0_sample),
		.sample_valid    (core0_sample_valid),
		.trim            (s.trim0[AMO_TRIM_W-1:0]),
		.corrected       (core0_corrected),
		.corrected_valid (core0_corrected_valid)
	);

	amo_trim_apply #(
		.SAMPLE_W(SAMPLE_W)
	) u_core1_trim (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.sample          (core1_sample),
		.sample_valid    (core1_sample_valid),
		.trim            (s.trim1[AMO_TRIM_W-1:0]),
		.corrected       (core1_corrected),
		.corrected_valid (core1_corrected_valid)
	);

	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign summary_alarm = s.summary;
	assign spare_core_fg_offset_cal = s.calstat[AMO_BIT_SPARE_FG];

endmodule : amo_regs
`default_nettype wire

// file: tb/amo_regs_sva.sv
// Port checker for the alarm mask and offset trim bank.
// Assumes one clock domain; aresetn synchronous, active low.
`timescale 1ns/10ps
`default_nettype none
module amo_regs_chk
	import amo_pkg::*;
(
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic                       awvalid,
	input wire logic                       awready,
	input wire logic                       wvalid,
	input wire logic                       wready,
	input wire logic [1:0]                 bresp,
	input wire logic                       bvalid,
	input wire logic                       bready,
	input wire logic                       arvalid,
	input wire logic                       arready,
	input wire logic [31:0]                rdata,
	input wire logic                       rvalid,
	input wire logic                       rready,
	input wire amo_pkg::amo_alarm_src_type alarm_src,
	input wire logic                       soft_reset,
	input wire amo_pkg::amo_cal_state_type cal_state,
	input wire logic                       summary_alarm,
	input wire logic                       spare_core_fg_offset_cal,
	input wire logic                       core0_sample_valid,
	input wire logic                       core0_corrected_valid,
	input wire logic                       core1_sample_valid,
	input wire logic                       core1_corrected_valid
);
	wire logic cause;
	wire logic spare_due;

	// Mask writes can also raise the summary, not only sources
	assign cause = (|alarm_src) || wvalid || soft_reset;
	assign spare_due = cal_state.offset_cal_enable
		&& cal_state.background_cal_enable
		&& !cal_state.continuous_offset_tracking_enable;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

////////////////////////////////////////////////////////////////////////////
	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	property p_wr_resp;
		s_wr_take |=> bvalid && !awready && !wready;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write not answered");
	property p_rd_resp;
		s_rd_take |=> rvalid && !arready;
	endproperty
	a_rd_resp: assert property (p_rd_resp)
		else $error("read not answered");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	property p_sum_cause;
		$rose(summary_alarm) |-> $past(cause) || $past(cause, 2);
	endproperty
	a_sum_cause: assert property (p_sum_cause)
		else $error("summary rose without cause");
	property p_spare;
		spare_core_fg_offset_cal == $past(spare_due);
	endproperty
	a_spare: assert property (p_spare)
		else $error("spare core cal flag wrong");
	property p_trim0_valid;
		core0_sample_valid |=> core0_corrected_valid;
	endproperty
	a_trim0_valid: assert property (p_trim0_valid)
		else $error("core 0 sample lost");
	property p_trim1_valid;
		core1_corrected_valid == $past(core1_sample_valid);
	endproperty
	a_trim1_valid: assert property (p_trim1_valid)
		else $error("core 1 valid not delayed copy");
endmodule : amo_regs_chk

bind amo_regs amo_regs_chk u_amo_regs_chk (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
	.bready, .arvalid, .arready, .rdata, .rvalid, .rready, .alarm_src,
	.soft_reset, .cal_state, .summary_alarm, .spare_core_fg_offset_cal,
	.core0_sample_valid, .core0_corrected_valid, .core1_sample_valid,
	.core1_corrected_valid
);
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the alarm mask and offset trim bank.
// Assumes amo_pkg and the checker with its bind are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import amo_pkg::*;
	localparam logic [11:0] A_STAT = {AMO_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_MASK = {AMO_IDX_MASK, 2'b00};
	localparam logic [11:0] A_LANE = {AMO_IDX_LANE, 2'b00};
	localparam logic [11:0] A_SUM  = {AMO_IDX_SUMMARY, 2'b00};
	localparam logic [11:0] A_CAL  = {AMO_IDX_CALSTAT, 2'b00};
	localparam logic [11:0] A_T0   = {AMO_IDX_TRIM0, 2'b00};
	localparam logic [11:0] A_T1   = {AMO_IDX_TRIM1, 2'b00};

	logic              aclk, aresetn, soft_reset, summary_alarm;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [11:0]       awaddr, araddr;
	logic [31:0]       wdata, rdata, got;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, resp;
	logic              spare_core_fg_offset_cal;
	logic [11:0]       core0_sample, core1_sample;
	logic [11:0]       core0_corrected, core1_corrected;
	logic              core0_sample_valid, core1_sample_valid;
	logic              core0_corrected_valid, core1_corrected_valid;
	amo_alarm_src_type alarm_src;
	amo_cal_state_type cal_state;
	int                n_mismatch, tests_run, i;
	// One source per alarm field, and the mask bit that guards it
	logic [11:0]       srcs [5] = '{12'h010, 12'h008, 12'h004, 12'h002, 12'h001};
	logic [7:0]        mbit [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
	// Calibration states and the status word they should read back
	logic [4:0]        cs [5] = '{5'h18, 5'h1a, 5'h1c, 5'h01, 5'h00};
	logic [31:0]       ce [5] = '{32'h2, 32'h3, 32'h0, 32'h4, 32'h1};

	amo_regs u_amo_regs (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .alarm_src, .soft_reset, .cal_state,
		.summary_alarm, .spare_core_fg_offset_cal, .core0_sample,
		.core0_sample_valid, .core0_corrected, .core0_corrected_valid,
		.core1_sample, .core1_sample_valid, .core1_corrected,
		.core1_corrected_valid
	);

	always #10 aclk = ~aclk;

////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic fail();
		n_mismatch++;
		test_done();
	endtask : fail

	// Ready idles high; late drops it so the slave must hold its answer
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input bit late = 1'b0);
		int n;
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		if (late)
			bready <= 1'b0;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready) begin
				resp = bresp;
				return;
			end
			if (bvalid)
				bready <= 1'b1;
		end
		fail();
	endtask : wr

	task automatic rd(input logic [11:0] a, input bit late = 1'b0);
		int n;
		araddr  <= a;
		arvalid <= 1'b1;
		if (late)
			rready <= 1'b0;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				got = rdata;
				resp = rresp;
				return;
			end
			if (rvalid)
				rready <= 1'b1;
		end
		fail();
	endtask : rd

	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		chk(got, e);
	endtask : rc

	task automatic pulse(input logic [11:0] s);
		alarm_src <= amo_alarm_src_type'(s);
		@(posedge aclk);
		alarm_src <= '0;
		repeat (2) @(posedge aclk);
	endtask : pulse

////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		{aresetn, awvalid, wvalid, arvalid, soft_reset} = '0;
		{bready, rready} = 2'h3;
		{awaddr, araddr, wdata, wstrb, alarm_src, cal_state} = '0;
		{core0_sample, core1_sample, core0_sample_valid, core1_sample_valid} = '0;
		n_mismatch = 0;
		tests_run = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(A_MASK, 32'h3f);
		rc(A_LANE, 32'hff);
		rc(A_STAT, 32'h3f);
		rc(A_T0, 32'h0);
		rc(A_T1, 32'h0);
		rc(A_SUM, 32'h0);
		rd(12'h004, 1'b1);
		chk(32'(resp), 32'(AMO_RESP_SLVERR));
		wr(12'h004, 32'h1, 1'b1);
		chk(32'(resp), 32'(AMO_RESP_SLVERR));
		// Lane flags: partial clear, bulk clear, sticky set, re-trip
		wr(A_LANE, 32'h01);
		rc(A_LANE, 32'hfe);
		wr(A_STAT, 32'h20);
		rc(A_LANE, 32'h0);
		rc(A_STAT, 32'h1f);
		pulse(12'h080);
		rc(A_LANE, 32'h08);
		rc(A_STAT, 32'h3f);
		alarm_src <= amo_alarm_src_type'(12'h200);
		wr(A_LANE, 32'h28);
		alarm_src <= '0;
		rc(A_LANE, 32'h20);
		wr(A_LANE, 32'hff);
		rc(A_LANE, 32'h0);
		// Each source unmasked alone; the others must not leak through
		for (i = 0; i < 5; i++) begin
			wr(A_STAT, 32'h3f);
			wr(A_MASK, 32'(8'h3f & ~mbit[i]));
			pulse(12'h01f & ~srcs[i]);
			chk(32'(summary_alarm), 32'h0);
			pulse(srcs[i]);
			chk(32'(summary_alarm), 32'h1);
			rc(A_SUM, 32'h1);
			wr(A_MASK, 32'h3f);
			chk(32'(summary_alarm), 32'h0);
		end
		wr(A_STAT, 32'h3f);
		soft_reset <= 1'b1;
		@(posedge aclk);
		soft_reset <= 1'b0;
		@(posedge aclk);
		rc(A_STAT, 32'h3f);
		// Trim: plain add on core 0, saturation on core 1
		wr(A_T0, 32'h0abc);
		chk(32'(resp), 32'(AMO_RESP_OKAY));
		rc(A_T0, 32'h0abc);
		chk(32'(resp), 32'(AMO_RESP_OKAY));
		wr(A_T1, 32'h0fff);
		rc(A_T1, 32'h0fff);
		core0_sample <= 12'h100;
		core1_sample <= 12'h010;
		{core0_sample_valid, core1_sample_valid} <= 2'h3;
		@(posedge aclk);
		{core0_sample_valid, core1_sample_valid} <= 2'h0;
		@(posedge aclk);
		chk(32'(core0_corrected), 32'h0bbc);
		chk(32'(core1_corrected), 32'h0fff);
		chk(32'({core0_corrected_valid, core1_corrected_valid}), 32'h3);
		for (i = 0; i < 5; i++) begin
			cal_state <= amo_cal_state_type'(cs[i]);
			repeat (3) @(posedge aclk);
			chk(32'(spare_core_fg_offset_cal), 32'(ce[i][1]));
			rc(A_CAL, ce[i]);
		end
		// Reset again in mid-run after the mask and trims changed
		wr(A_MASK, 32'h02);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(A_MASK, 32'h3f);
		rc(A_T0, 32'h0);
		rc(A_LANE, 32'hff);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
